/* bench/latched_flag_status_bank_asserts.sv */
module latched_flag_status_bank_asserts (
	input wire                         I_CLK_SYS,
	input wire                         I_RST,
	input wire                         I_MODULE_RESET_N,
	input wire                         I_SCL,
	input flag_status_pkg::flag_cond_t I_FLAG_COND,
	input flag_status_pkg::flag_cond_t I_FLAG_MASK,
	input wire                         O_INTERRUPT_OUT_N
);
	logic [7:0] quiet;
	logic       unmasked;
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	assign unmasked = |(I_FLAG_COND & ~I_FLAG_MASK);
	// Cycles with no bus clock, reset pin or mask change: nothing may clear a flag then
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST || !$stable(I_SCL) || !$stable(I_MODULE_RESET_N) || !$stable(I_FLAG_MASK)) begin
			quiet <= 8'h00;
		end else if (quiet != 8'hff) begin
			quiet <= quiet + 8'h01;
		end
	end
	property p_int_set;
		unmasked && I_MODULE_RESET_N && $past(I_MODULE_RESET_N, 4) |-> ##[1:3] !O_INTERRUPT_OUT_N;
	endproperty
	a_int_set: assert property (p_int_set) else $error("interrupt not raised");
	property p_persist;
		(unmasked && I_MODULE_RESET_N) [*5] |-> !O_INTERRUPT_OUT_N;
	endproperty
	a_persist: assert property (p_persist) else $error("persistent condition lost");
	property p_mask_all;
		(&I_FLAG_MASK) [*3] |-> O_INTERRUPT_OUT_N;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("masked interrupt seen");
	property p_mrst_hold;
		!I_MODULE_RESET_N [*6] |-> O_INTERRUPT_OUT_N;
	endproperty
	a_mrst_hold: assert property (p_mrst_hold) else $error("interrupt during module reset");
	property p_mrst_fall;
		$fell(I_MODULE_RESET_N) |-> ##[2:5] O_INTERRUPT_OUT_N;
	endproperty
	a_mrst_fall: assert property (p_mrst_fall) else $error("module reset did not clear");
	property p_latched;
		quiet > 8'd8 && $stable(I_FLAG_MASK) && I_MODULE_RESET_N && !O_INTERRUPT_OUT_N |=> !O_INTERRUPT_OUT_N;
	endproperty
	a_latched: assert property (p_latched) else $error("flag dropped without read");
	property p_cause;
		$fell(O_INTERRUPT_OUT_N) |-> $past(unmasked, 2) || $past(I_FLAG_MASK) != $past(I_FLAG_MASK, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("interrupt without cause");
	property p_mrst_clean;
		!I_MODULE_RESET_N [*6] ##1 (I_MODULE_RESET_N && !unmasked) [*3] |-> O_INTERRUPT_OUT_N;
	endproperty
	a_mrst_clean: assert property (p_mrst_clean) else $error("flag survived module reset");
endmodule

bind latched_flag_status_bank latched_flag_status_bank_asserts u_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_MODULE_RESET_N(I_MODULE_RESET_N), .I_SCL(I_SCL),
	.I_FLAG_COND(I_FLAG_COND), .I_FLAG_MASK(I_FLAG_MASK), .O_INTERRUPT_OUT_N(O_INTERRUPT_OUT_N)
);

/* bench/latched_flag_status_bank_tb_top.sv */
module latched_flag_status_bank_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                        clk = 1'b0;
	logic                        rst = 1'b1;
	logic                        module_reset_n = 1'b1;
	logic                        monitor_ready = 1'b0;
	flag_status_pkg::flag_cond_t cond = '0;
	flag_status_pkg::flag_cond_t mask = '0;
	flag_status_pkg::flag_cond_t pat [4] = '{64'h0, 64'h1248c3a50f967e18, 64'hedb73c5af06981e7, 64'h0};
	logic                        scl, sda_low, sda_oe, int_n, sda_out;
	wire                         sda;
	int                          error_cnt, n_checks, cyc;
	// Pulled up unless either side pulls low; the device drives its own data value while enabled
	assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
	always #5 clk = ~clk;
	latched_flag_status_bank dut (.I_CLK_SYS(clk), .I_RST(rst), .I_MODULE_RESET_N(module_reset_n), .I_SCL(scl),
		.I_SDA(sda), .O_SDA(sda_out), .O_SDA_OE(sda_oe), .I_FLAG_COND(cond), .I_FLAG_MASK(mask),
		.I_MONITOR_READY(monitor_ready), .O_INTERRUPT_OUT_N(int_n));
	twowire_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	function automatic logic [7:0] expect_byte(flag_status_pkg::flag_cond_t c, int a);
		case (a)
			3: return {4'h0, c.rx_los};
			4: return {4'h0, c.tx_fault};
			6: return {c.temp, 4'h0};
			7: return {c.vcc, 4'h0};
			9: return c.rx_power[15:8];
			10: return c.rx_power[7:0];
			11: return c.tx_bias[15:8];
			12: return c.tx_bias[7:0];
			13: return c.tx_power[15:8];
			14: return c.tx_power[7:0];
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask
	// A refused transfer yields unknown data so it can never pass
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       k;
		host.access(1'b0, a, 8'h00, d, k);
		chk($sformatf("byte %0d", a), e, k ? 8'hxx : d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] d;
		logic       k;
		host.access(1'b1, a, v, d, k);
		chk("write ack", 8'h00, {7'h00, k});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic final_report();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		tick(16);
		rst = 1'b0;
		tick(4);
		rc(8'h02, 8'h03);
		rc(8'h01, 8'h00);
		rc(8'h16, 8'h00);
		monitor_ready = 1'b1;
		tick(4);
		foreach (pat[i]) begin
			cond = pat[i];
			tick(1);
			cond = '0;
			tick(4);
			chk("interrupt", {7'h00, pat[i] == '0}, {7'h00, int_n});
			rc(8'h02, {6'h00, pat[i] == '0, 1'b0});
			for (int a = 3; a <= 21; a++) rc(8'(a), expect_byte(pat[i], a));
			chk("interrupt", 8'h01, {7'h00, int_n});
		end
		cond = pat[1];
		tick(3);
		rc(8'h03, expect_byte(pat[1], 3));
		rc(8'h03, expect_byte(pat[1], 3));
		mask = '1;
		cond = '0;
		tick(3);
		chk("masked interrupt", 8'h01, {7'h00, int_n});
		mask = '0;
		tick(3);
		chk("interrupt", 8'h00, {7'h00, int_n});
		wr(8'h03, 8'h00);
		wr(8'h02, 8'hff);
		rc(8'h02, 8'h00);
		rc(8'h03, expect_byte(pat[1], 3));
		module_reset_n = 1'b0;
		tick(3);
		cond = pat[2];
		tick(5);
		cond = '0;
		tick(1);
		module_reset_n = 1'b1;
		tick(4);
		chk("interrupt", 8'h01, {7'h00, int_n});
		for (int a = 3; a <= 21; a++) rc(8'(a), 8'h00);
		final_report();
	end
endmodule

/* bench/twowire_host.sv */
module twowire_host (
	input  wire  i_clk,
	input  wire  i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Quarter of an 80 ns bit, aligned just after a system clock edge
	task automatic q(input int n);
		repeat (2 * n) @(posedge i_clk);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		q(1);
		o_scl = 1'b1;
		q(1);
		r = i_sda;
		q(1);
		o_scl = 1'b0;
		q(1);
	endtask
	task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
		bit_io(last, ack);
	endtask
	task automatic start();
		o_sda_low = 1'b0;
		q(1);
		o_scl = 1'b1;
		q(2);
		o_sda_low = 1'b1;
		q(2);
		o_scl = 1'b0;
		q(1);
	endtask
	// Clock idles high between frames, as the bus requires
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] v, output logic [7:0] d,
		output logic nack);
		logic [7:0] r;
		logic       k;
		start();
		byte_io({flag_status_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, r, nack);
		byte_io(a, 1'b1, r, k);
		nack |= k;
		if (wr) begin
			byte_io(v, 1'b1, r, k);
		end else begin
			start();
			byte_io({flag_status_pkg::DEVICE_ADDRESS, 1'b1}, 1'b1, r, k);
			byte_io(8'hff, 1'b1, d, r[0]);
		end
		nack |= k;
		o_sda_low = 1'b1;
		q(1);
		o_scl = 1'b1;
		q(2);
		o_sda_low = 1'b0;
		q(2);
	endtask
endmodule

/* hdl/flag_status_pkg.sv */
package flag_status_pkg;

	// Nibble fields: bit 3 is channel 4 for per-channel bits; alarm nibbles are
	// {high alarm, low alarm, high warning, low warning}; 16-bit groups are {ch1,ch2,ch3,ch4}
	typedef struct packed {
		logic [3:0]  rx_los;
		logic [3:0]  tx_fault;
		logic [3:0]  temp;
		logic [3:0]  vcc;
		logic [15:0] rx_power;
		logic [15:0] tx_bias;
		logic [15:0] tx_power;
	} flag_cond_t;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_DEV_ADDR  = 4'h1,
		ST_DEV_ACK   = 4'h3,
		ST_WORD_ADDR = 4'h2,
		ST_WORD_ACK  = 4'h6,
		ST_WR_DATA   = 4'h7,
		ST_WR_ACK    = 4'h5,
		ST_RD_DATA   = 4'h4,
		ST_RD_ACK    = 4'hc
	} link_state_t;

	localparam logic [6:0] DEVICE_ADDRESS       = 7'h50;
	localparam logic [7:0] OFS_STATUS_RESERVED  = 8'h01;
	localparam logic [7:0] OFS_MODULE_STATUS    = 8'h02;
	localparam logic [7:0] OFS_SIGNAL_LOSS      = 8'h03;
	localparam logic [7:0] OFS_TX_FAULT         = 8'h04;
	localparam logic [7:0] OFS_CHANNEL_RESERVED = 8'h05;
	localparam logic [7:0] OFS_TEMPERATURE      = 8'h06;
	localparam logic [7:0] OFS_SUPPLY_VOLTAGE   = 8'h07;
	localparam logic [7:0] OFS_MODULE_RESERVED  = 8'h08;
	localparam logic [7:0] OFS_RX_POWER_CH12    = 8'h09;
	localparam logic [7:0] OFS_RX_POWER_CH34    = 8'h0a;
	localparam logic [7:0] OFS_TX_BIAS_CH12     = 8'h0b;
	localparam logic [7:0] OFS_TX_BIAS_CH34     = 8'h0c;
	localparam logic [7:0] OFS_TX_POWER_CH12    = 8'h0d;
	localparam logic [7:0] OFS_TX_POWER_CH34    = 8'h0e;
	localparam logic [7:0] OFS_SET4_RESERVED    = 8'h0f;
	localparam logic [7:0] OFS_SET5_RESERVED    = 8'h11;
	localparam logic [7:0] OFS_SET6_RESERVED    = 8'h13;
	localparam logic [7:0] OFS_TAIL_RESERVED    = 8'h15;
	localparam int         FLAG_FIRST           = 3;
	localparam int         FLAG_LAST            = 21;
	localparam int         BIT_INTERRUPT        = 1;
	localparam int         BIT_NOT_READY        = 0;
	localparam logic [7:0] FLAG_RESET           = 8'h00;
	localparam logic       NOT_READY_RESET      = 1'b1;
	localparam logic [2:0] BIT_COUNT_LAST       = 3'h7;

endpackage

/* hdl/latched_flag_status_bank.sv */
module latched_flag_status_bank (
	input  wire                         I_CLK_SYS,
	input  wire                         I_RST,
	input  wire                         I_MODULE_RESET_N,
	input  wire                         I_SCL,
	input  wire                         I_SDA,
	output logic                        O_SDA,
	output logic                        O_SDA_OE,
	input  flag_status_pkg::flag_cond_t I_FLAG_COND,
	input  flag_status_pkg::flag_cond_t I_FLAG_MASK,
	input  wire                         I_MONITOR_READY,
	output logic                        O_INTERRUPT_OUT_N
);

	logic [2:0]                   scl_sync;
	logic [2:0]                   sda_sync;
	logic [1:0]                   reset_sync;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         start_seen;
	logic                         stop_seen;
	logic                         module_reset;
	flag_status_pkg::link_state_t state;
	logic [2:0]                   bit_count;
	logic                         byte_done;
	logic [7:0]                   shift_in;
	logic [7:0]                   shift_out;
	logic                         read_mode;
	logic                         host_ack;
	logic [7:0]                   pointer;
	logic [7:0]                   read_data;
	logic                         load_byte;
	logic                         data_not_ready;
	logic [7:0]                   flags [flag_status_pkg::FLAG_FIRST:flag_status_pkg::FLAG_LAST];
	logic                         next_interrupt_n;

	// Places the condition or mask bits of one flag byte; reserved bits stay zero
	function automatic logic [7:0] flag_bits(input flag_status_pkg::flag_cond_t c, input logic [7:0] ofs);
		logic [7:0] b;
		b = 8'h00;
		if (ofs == flag_status_pkg::OFS_SIGNAL_LOSS) begin
			b = {4'h0, c.rx_los};
		end else if (ofs == flag_status_pkg::OFS_TX_FAULT) begin
			b = {4'h0, c.tx_fault};
		end else if (ofs == flag_status_pkg::OFS_TEMPERATURE) begin
			b = {c.temp, 4'h0};
		end else if (ofs == flag_status_pkg::OFS_SUPPLY_VOLTAGE) begin
			b = {c.vcc, 4'h0};
		end else if (ofs == flag_status_pkg::OFS_RX_POWER_CH12) begin
			b = c.rx_power[15:8];
		end else if (ofs == flag_status_pkg::OFS_RX_POWER_CH34) begin
			b = c.rx_power[7:0];
		end else if (ofs == flag_status_pkg::OFS_TX_BIAS_CH12) begin
			b = c.tx_bias[15:8];
		end else if (ofs == flag_status_pkg::OFS_TX_BIAS_CH34) begin
			b = c.tx_bias[7:0];
		end else if (ofs == flag_status_pkg::OFS_TX_POWER_CH12) begin
			b = c.tx_power[15:8];
		end else if (ofs == flag_status_pkg::OFS_TX_POWER_CH34) begin
			b = c.tx_power[7:0];
		end
		return b; // Bytes 5, 8 and 15 to 21 fall through as zero
	endfunction

	// Pins from outside the clock domain pass two flops; the third stage only serves edge detection
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			scl_sync   <= 3'h7;
			sda_sync   <= 3'h7;
			reset_sync <= 2'h3;
		end else begin
			scl_sync   <= {scl_sync[1:0], I_SCL};
			sda_sync   <= {sda_sync[1:0], I_SDA};
			reset_sync <= {reset_sync[0], I_MODULE_RESET_N};
		end
	end

	assign scl_rise     = scl_sync[1] & ~scl_sync[2];
	assign scl_fall     = ~scl_sync[1] & scl_sync[2];
	assign start_seen   = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign stop_seen    = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
	assign module_reset = ~reset_sync[1];

	// Open-drain data line: only ever pulled low
	assign O_SDA = 1'b0;

	// A byte is fetched for the host on the falling edge that ends an acknowledge
	assign load_byte = scl_fall & ~start_seen & ~stop_seen &
		((state == flag_status_pkg::ST_DEV_ACK & read_mode) |
		 (state == flag_status_pkg::ST_RD_ACK & host_ack));

	always_comb begin
		read_data = 8'h00;
		if (pointer == flag_status_pkg::OFS_MODULE_STATUS) begin
			read_data                                = 8'h00;
			read_data[flag_status_pkg::BIT_INTERRUPT] = O_INTERRUPT_OUT_N;
			read_data[flag_status_pkg::BIT_NOT_READY] = data_not_ready;
		end else if (pointer >= 8'(flag_status_pkg::FLAG_FIRST) && pointer <= 8'(flag_status_pkg::FLAG_LAST)) begin
			read_data = flags[pointer[4:0]];
		end
	end

	// Two-wire slave: sample on rising SCL, change SDA on falling SCL
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			state     <= flag_status_pkg::ST_IDLE;
			bit_count <= 3'h0;
			byte_done <= 1'b0;
			shift_in  <= 8'h00;
			shift_out <= 8'h00;
			read_mode <= 1'b0;
			host_ack  <= 1'b0;
			pointer   <= 8'h00;
			O_SDA_OE  <= 1'b0;
		end else if (start_seen) begin
			state     <= flag_status_pkg::ST_DEV_ADDR;
			bit_count <= 3'h0;
			byte_done <= 1'b0;
			O_SDA_OE  <= 1'b0;
		end else if (stop_seen) begin
			state    <= flag_status_pkg::ST_IDLE;
			O_SDA_OE <= 1'b0;
		end else if (scl_rise) begin
			if (state == flag_status_pkg::ST_RD_ACK) begin
				host_ack <= ~sda_sync[1];
			end else if (state == flag_status_pkg::ST_DEV_ADDR || state == flag_status_pkg::ST_WORD_ADDR ||
				state == flag_status_pkg::ST_WR_DATA || state == flag_status_pkg::ST_RD_DATA) begin
				shift_in  <= {shift_in[6:0], sda_sync[1]};
				bit_count <= bit_count + 3'h1;
				if (bit_count == flag_status_pkg::BIT_COUNT_LAST) begin
					byte_done <= 1'b1;
				end
			end
		end else if (scl_fall) begin
			case (state)
				flag_status_pkg::ST_DEV_ADDR: begin
					if (byte_done) begin
						if (shift_in[7:1] == flag_status_pkg::DEVICE_ADDRESS) begin
							read_mode <= shift_in[0];
							O_SDA_OE  <= 1'b1;
							state     <= flag_status_pkg::ST_DEV_ACK;
						end else begin
							state <= flag_status_pkg::ST_IDLE;
						end
					end
				end
				flag_status_pkg::ST_DEV_ACK: begin
					byte_done <= 1'b0;
					bit_count <= 3'h0;
					if (read_mode) begin
						shift_out <= read_data;
						O_SDA_OE  <= ~read_data[7];
						pointer   <= pointer + 8'h01;
						state     <= flag_status_pkg::ST_RD_DATA;
					end else begin
						O_SDA_OE <= 1'b0;
						state    <= flag_status_pkg::ST_WORD_ADDR;
					end
				end
				flag_status_pkg::ST_WORD_ADDR: begin
					if (byte_done) begin
						pointer  <= shift_in;
						O_SDA_OE <= 1'b1;
						state    <= flag_status_pkg::ST_WORD_ACK;
					end
				end
				flag_status_pkg::ST_WR_DATA: begin
					// Data is acknowledged but dropped: everything here is read-only
					if (byte_done) begin
						pointer  <= pointer + 8'h01;
						O_SDA_OE <= 1'b1;
						state    <= flag_status_pkg::ST_WR_ACK;
					end
				end
				flag_status_pkg::ST_WORD_ACK, flag_status_pkg::ST_WR_ACK: begin
					byte_done <= 1'b0;
					bit_count <= 3'h0;
					O_SDA_OE  <= 1'b0;
					state     <= flag_status_pkg::ST_WR_DATA;
				end
				flag_status_pkg::ST_RD_DATA: begin
					if (byte_done) begin
						O_SDA_OE <= 1'b0;
						host_ack <= 1'b0;
						state    <= flag_status_pkg::ST_RD_ACK;
					end else begin
						shift_out <= {shift_out[6:0], 1'b0};
						O_SDA_OE  <= ~shift_out[6];
					end
				end
				flag_status_pkg::ST_RD_ACK: begin
					byte_done <= 1'b0;
					bit_count <= 3'h0;
					if (host_ack) begin
						shift_out <= read_data;
						O_SDA_OE  <= ~read_data[7];
						pointer   <= pointer + 8'h01;
						state     <= flag_status_pkg::ST_RD_DATA;
					end else begin
						state <= flag_status_pkg::ST_IDLE;
					end
				end
				default: begin
					O_SDA_OE <= 1'b0;
				end
			endcase
		end
	end

	// Clear of a fetched byte and a condition in the same cycle: the condition wins
	always_ff @(posedge I_CLK_SYS) begin
		for (int i = flag_status_pkg::FLAG_FIRST; i <= flag_status_pkg::FLAG_LAST; i++) begin
			if (I_RST || module_reset) begin
				flags[i] <= flag_status_pkg::FLAG_RESET;
			end else if (load_byte && pointer == 8'(i)) begin
				flags[i] <= flag_bits(I_FLAG_COND, 8'(i));
			end else begin
				flags[i] <= flags[i] | flag_bits(I_FLAG_COND, 8'(i));
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			data_not_ready <= flag_status_pkg::NOT_READY_RESET;
		end else if (I_MONITOR_READY) begin
			data_not_ready <= 1'b0;
		end
	end

	// A set mask bit hides that flag from the pin but not from the byte
	always_comb begin
		next_interrupt_n = 1'b1;
		for (int i = flag_status_pkg::FLAG_FIRST; i <= flag_status_pkg::FLAG_LAST; i++) begin
			if (|(flags[i] & ~flag_bits(I_FLAG_MASK, 8'(i)))) begin
				next_interrupt_n = 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_INTERRUPT_OUT_N <= 1'b1;
		end else begin
			O_INTERRUPT_OUT_N <= next_interrupt_n;
		end
	end

endmodule
